// ===== cbc_pkg.sv
// Constants and types shared by the machine-cycle and bus controller.
// Assumes a single 50 MHz clock and an APB register port.
package cbc_pkg;

    localparam int CLK_PERIOD_NS = 20;
    localparam int CYC_CLKS      = 8;

    // Phases within one machine cycle; outputs appear one clock later
    localparam logic [2:0] PH_ALP     = 3'h1;
    localparam logic [2:0] PH_HI_LAST = 3'h2;
    localparam logic [2:0] PH_STB_LO  = 3'h2;
    localparam logic [2:0] PH_STB_HI  = 3'h6;
    localparam logic [2:0] PH_WR_LO   = 3'h5;
    localparam logic [2:0] PH_DLP     = 3'h6;
    localparam logic [2:0] PH_LAST    = 3'h7;

    // APB register byte offsets
    localparam logic [7:0] A_CTRL  = 8'h00;
    localparam logic [7:0] A_STAT  = 8'h04;
    localparam logic [7:0] A_SEL   = 8'h08;
    localparam logic [7:0] A_PIDX  = 8'h0c;
    localparam logic [7:0] A_PDATA = 8'h10;

    // Field positions
    localparam int F_RUN  = 0;
    localparam int F_IE   = 1;
    localparam int F_SC   = 0;
    localparam int F_Q    = 2;
    localparam int F_HALT = 4;
    localparam int F_P    = 8;
    localparam int F_X    = 12;
    localparam int F_D    = 16;
    localparam int F_SELX = 4;

    // Reset and fixed selector values
    localparam logic [3:0] RST_SEL = 4'h0;
    localparam logic [3:0] DMA_PTR = 4'h0;
    localparam logic [3:0] INT_P   = 4'h1;
    localparam logic [3:0] INT_X   = 4'h2;

    // Opcode groups (high nibble) and Q codes (low nibble)
    localparam logic [3:0] OP_INC  = 4'h1;
    localparam logic [3:0] OP_DEC  = 4'h2;
    localparam logic [3:0] OP_SBR  = 4'h3;
    localparam logic [3:0] OP_LDA  = 4'h4;
    localparam logic [3:0] OP_STR  = 4'h5;
    localparam logic [3:0] OP_IO   = 4'h6;
    localparam logic [3:0] OP_Q    = 4'h7;
    localparam logic [3:0] OP_LBR  = 4'hc;
    localparam logic [3:0] OP_SETP = 4'hd;
    localparam logic [3:0] OP_SETX = 4'he;
    localparam logic [3:0] Q_SET   = 4'hb;
    localparam logic [3:0] Q_CLR   = 4'ha;

    // State code lines
    localparam logic [1:0] SC_FETCH = 2'h0;
    localparam logic [1:0] SC_EXEC  = 2'h1;
    localparam logic [1:0] SC_DMA   = 2'h2;
    localparam logic [1:0] SC_INT   = 2'h3;

    typedef enum {ST_HALT, ST_FETCH, ST_EXEC, ST_EXEC2, ST_DMA, ST_INTR} cbc_state_e;

    typedef struct packed {
        logic [7:0] addr;
        logic       address_high_latch_pulse;
        logic       data_latch_pulse;
        logic       rd_n;
        logic       wr_n;
        logic [1:0] state_code;
        logic [2:0] io_sel;
        logic [7:0] dout;
        logic       doe;
    } cbc_bus_s;

endpackage : cbc_pkg

// ===== cbc_cpu_bus_ctrl.sv
// Machine-cycle sequencer and external bus driver with APB control.
// Assumes synchronous inputs, external address latch, one clock.
//
// Contract
// - Sixteen 16-bit pointer registers serve as counters, pointers or data.
// - A 4-bit selector picks the fetch address register.
// - A 4-bit selector picks the stack pointer register.
// - A 4-bit selector picks the data transfer or operand register.
// - Any pointer register may address the full 64K space.
// - Any pointer register can be incremented or decremented.
// - High address byte goes out first with an address latch pulse.
// - Data bus is not multiplexed; a latch pulse marks stable data.
// - A 3-bit select bus is driven during I/O instructions.
// - DMA uses pointer register zero as its address counter.
// - An interrupt uses pointer register one as service vector.
// - Four testable flag inputs and one software-set output bit.
// - Two state code lines show the machine-cycle type.
// - Separate read and write strobes control memory.
// - A machine cycle is exactly eight clock periods.
// - Most instructions take one fetch plus one execute cycle.
// - Each DMA transfer takes one stolen machine cycle.
// - A DMA-in request during an instruction takes the cycle after its last execute cycle.
// - Back-to-back DMA-in stores bytes at consecutive addresses.
// - Input writes the byte to memory at stack address and accumulator.
// - Output execute places the stack register value on address lines.
// - Inherent instructions touch only registers, memory stays idle.
// - Each DMA cycle increments the DMA pointer afterwards.
// - Output sends the stack memory byte, then increments stack pointer.
// - Short branch takes two cycles, long branch three.
module cbc_cpu_bus_ctrl #(
    parameter int CLKS_PER_CYCLE = 8
) (
    input  wire logic             CLK,
    input  wire logic             RST,
    input  wire logic             PSEL,
    input  wire logic             PENABLE,
    input  wire logic             PWRITE,
    input  wire logic [7:0]       PADDR,
    input  wire logic [31:0]      PWDATA,
    output logic      [31:0]      PRDATA,
    output logic                  PREADY,
    output logic                  PSLVERR,
    input  wire logic [7:0]       DATA_IN,
    input  wire logic [3:0]       FLAG_IN,
    input  wire logic             DMA_IN_REQ,
    input  wire logic             INT_REQ,
    output logic                  Q_OUT,
    output cbc_pkg::cbc_bus_s     BUS
);
    import cbc_pkg::*;

    if (CLKS_PER_CYCLE != CYC_CLKS) begin : g_bad_len
        $error("Phase decode serves only eight clocks per cycle");
    end

    logic [2:0]  ph_r, io_sel;
    cbc_state_e  st_r, st_nxt, bnd;
    logic [15:0] ptr_r [16];
    logic [15:0] addr, cur_x;
    logic [3:0]  p_r, x_r, pidx_r, sel;
    logic [3:0]  ir_i, ir_n;
    logic [7:0]  ir_r, d_r, hold_r;
    logic [31:0] prdata_r;
    cbc_bus_s    bus_r;
    logic [1:0]  sc;
    logic        run_r, ie_r, q_r;
    logic        cyc_end, in_exec, halted, taken, apb_wr, hit;
    logic        output_instr, input_instruction, inherent;
    logic        mem_rd, mem_wr, drive;

    assign ir_i    = ir_r[7:4];
    assign ir_n    = ir_r[3:0];
    assign cyc_end = (ph_r == PH_LAST);
    assign in_exec = (st_r == ST_EXEC);
    assign halted  = (st_r == ST_HALT);
    assign cur_x   = ptr_r[x_r];
    assign taken   = FLAG_IN[ir_n[1:0]];

    assign output_instr      = (ir_i == OP_IO) && !ir_n[3] && (ir_n[2:0] != 3'h0);
    assign input_instruction = (ir_i == OP_IO) && ir_n[3] && (ir_n[2:0] != 3'h0);
    assign inherent = (ir_i == OP_INC) || (ir_i == OP_DEC) || (ir_i == OP_Q)
                   || (ir_i == OP_SETP) || (ir_i == OP_SETX) || (ir_r == 8'h00);

    // Machine-cycle divider; the counter wraps so each cycle is eight clocks
    always_ff @(posedge CLK) begin
        if (RST) begin
            ph_r <= 3'h0;
        end else begin
            ph_r <= ph_r + 3'h1;
        end
    end

    // Requests are only looked at here, at a cycle boundary
    always_comb begin
        if (!run_r) begin
            bnd = ST_HALT;
        end else if (DMA_IN_REQ) begin
            bnd = ST_DMA;
        end else if (INT_REQ && ie_r) begin
            bnd = ST_INTR;
        end else begin
            bnd = ST_FETCH;
        end
    end

    always_comb begin
        case (st_r)
            ST_FETCH: st_nxt = ST_EXEC;
            ST_EXEC: st_nxt = (ir_i == OP_LBR) ? ST_EXEC2 : bnd;
            default: st_nxt = bnd;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            st_r <= ST_HALT;
        end else if (cyc_end) begin
            st_r <= st_nxt;
        end
    end

    // Address source per cycle type
    always_comb begin
        case (st_r)
            ST_EXEC: begin
                if (ir_i == OP_LDA || ir_i == OP_STR) begin
                    sel = ir_n;
                end else if (ir_i == OP_IO) begin
                    sel = x_r;
                end else begin
                    sel = p_r;
                end
            end
            ST_DMA: sel = DMA_PTR;
            default: sel = p_r;
        endcase
    end

    assign addr = ptr_r[sel];

    always_comb begin
        mem_rd = 1'b0;
        mem_wr = 1'b0;
        drive  = 1'b0;
        io_sel = 3'h0;
        sc     = SC_FETCH;
        case (st_r)
            ST_FETCH: mem_rd = 1'b1;
            ST_EXEC: begin
                sc = SC_EXEC;
                mem_rd = (ir_i == OP_SBR) || (ir_i == OP_LDA)
                      || (ir_i == OP_LBR) || output_instr;
                mem_wr = (ir_i == OP_STR) || input_instruction;
                drive  = (ir_i == OP_STR);
                if (ir_i == OP_IO) begin
                    io_sel = ir_n[2:0];
                end
            end
            ST_EXEC2: begin
                sc = SC_EXEC;
                mem_rd = 1'b1;
            end
            ST_DMA: begin
                sc = SC_DMA;
                mem_wr = 1'b1;
            end
            ST_INTR: sc = SC_INT;
            default: sc = SC_FETCH;
        endcase
    end

    // Bus outputs are registered; they trail the phase counter by one clock
    always_ff @(posedge CLK) begin
        if (RST) begin
            bus_r <= '0;
            bus_r.rd_n <= 1'b1;
            bus_r.wr_n <= 1'b1;
        end else begin
            if (ph_r <= PH_HI_LAST) begin
                bus_r.addr <= addr[15:8];
            end else begin
                bus_r.addr <= addr[7:0];
            end
            bus_r.address_high_latch_pulse <= (ph_r == PH_ALP) && !halted;
            bus_r.data_latch_pulse <= (ph_r == PH_DLP) && !halted;
            bus_r.rd_n <= !(mem_rd && ph_r >= PH_STB_LO && ph_r <= PH_STB_HI);
            bus_r.wr_n <= !(mem_wr && ph_r >= PH_WR_LO && ph_r <= PH_STB_HI);
            bus_r.state_code <= sc;
            bus_r.io_sel <= io_sel;
            bus_r.dout <= d_r;
            bus_r.doe <= drive && ph_r >= PH_STB_LO && ph_r <= PH_STB_HI;
        end
    end

    assign BUS   = bus_r;
    assign Q_OUT = q_r;

    assign apb_wr = PSEL && PENABLE && PWRITE;

    // Pointer file; host writes are allowed only while halted
    always_ff @(posedge CLK) begin
        if (RST) begin
            for (int i = 0; i < 16; i++) begin
                ptr_r[i] <= 16'h0000;
            end
        end else if (apb_wr && PADDR == A_PDATA && halted) begin
            ptr_r[pidx_r] <= PWDATA[15:0];
        end else if (cyc_end) begin
            case (st_r)
                ST_FETCH: ptr_r[p_r] <= ptr_r[p_r] + 16'h0001;
                ST_EXEC: begin
                    case (ir_i)
                        OP_INC: ptr_r[ir_n] <= ptr_r[ir_n] + 16'h0001;
                        OP_DEC: ptr_r[ir_n] <= ptr_r[ir_n] - 16'h0001;
                        OP_LDA: ptr_r[ir_n] <= ptr_r[ir_n] + 16'h0001;
                        OP_LBR: ptr_r[p_r] <= ptr_r[p_r] + 16'h0001;
                        OP_SBR: begin
                            if (taken) begin
                                ptr_r[p_r] <= {ptr_r[p_r][15:8], DATA_IN};
                            end else begin
                                ptr_r[p_r] <= ptr_r[p_r] + 16'h0001;
                            end
                        end
                        OP_IO: begin
                            if (output_instr) begin
                                ptr_r[x_r] <= ptr_r[x_r] + 16'h0001;
                            end
                        end
                        default: ;
                    endcase
                end
                ST_EXEC2: ptr_r[p_r] <= {hold_r, DATA_IN};
                ST_DMA: ptr_r[DMA_PTR] <= ptr_r[DMA_PTR] + 16'h0001;
                default: ;
            endcase
        end
    end

    // Selectors, enables and the data path register
    always_ff @(posedge CLK) begin
        if (RST) begin
            p_r    <= RST_SEL;
            x_r    <= RST_SEL;
            ie_r   <= 1'b0;
            q_r    <= 1'b0;
            d_r    <= 8'h00;
            ir_r   <= 8'h00;
            hold_r <= 8'h00;
        end else begin
            if (apb_wr && PADDR == A_SEL && halted) begin
                p_r <= PWDATA[3:0];
                x_r <= PWDATA[F_SELX +: 4];
            end else if (cyc_end && st_r == ST_INTR) begin
                p_r <= INT_P;
                x_r <= INT_X;
            end else if (cyc_end && in_exec && ir_i == OP_SETP) begin
                p_r <= ir_n;
            end else if (cyc_end && in_exec && ir_i == OP_SETX) begin
                x_r <= ir_n;
            end
            // Interrupt entry must mask further requests, so it wins
            if (cyc_end && st_r == ST_INTR) begin
                ie_r <= 1'b0;
            end else if (apb_wr && PADDR == A_CTRL) begin
                ie_r <= PWDATA[F_IE];
            end
            if (cyc_end && in_exec && ir_r == {OP_Q, Q_SET}) begin
                q_r <= 1'b1;
            end else if (cyc_end && in_exec && ir_r == {OP_Q, Q_CLR}) begin
                q_r <= 1'b0;
            end
            if (cyc_end && st_r == ST_FETCH) begin
                ir_r <= DATA_IN;
            end
            if (cyc_end && in_exec && (ir_i == OP_LDA || input_instruction)) begin
                d_r <= DATA_IN;
            end
            if (cyc_end && in_exec && ir_i == OP_LBR) begin
                hold_r <= DATA_IN;
            end
        end
    end

    // APB: read data is taken in the setup cycle, answer in the access cycle
    always_ff @(posedge CLK) begin
        if (RST) begin
            run_r  <= 1'b0;
            pidx_r <= 4'h0;
        end else begin
            if (apb_wr && PADDR == A_CTRL) begin
                run_r <= PWDATA[F_RUN];
            end
            if (apb_wr && PADDR == A_PIDX) begin
                pidx_r <= PWDATA[3:0];
            end
        end
    end

    assign hit = (PADDR == A_CTRL) || (PADDR == A_STAT) || (PADDR == A_SEL)
              || (PADDR == A_PIDX) || (PADDR == A_PDATA);

    always_ff @(posedge CLK) begin
        if (RST) begin
            prdata_r <= 32'h0000_0000;
        end else if (PSEL && !PENABLE) begin
            prdata_r <= 32'h0000_0000;
            case (PADDR)
                A_CTRL: begin
                    prdata_r[F_RUN] <= run_r;
                    prdata_r[F_IE]  <= ie_r;
                end
                A_STAT: begin
                    prdata_r[F_SC +: 2] <= bus_r.state_code;
                    prdata_r[F_Q]       <= q_r;
                    prdata_r[F_IE + 2]  <= ie_r;
                    prdata_r[F_HALT]    <= halted;
                    prdata_r[F_P +: 4]  <= p_r;
                    prdata_r[F_X +: 4]  <= x_r;
                    prdata_r[F_D +: 8]  <= d_r;
                end
                A_SEL: prdata_r[7:0] <= {x_r, p_r};
                A_PIDX: prdata_r[3:0] <= pidx_r;
                A_PDATA: prdata_r[15:0] <= ptr_r[pidx_r];
                default: prdata_r <= 32'h0000_0000;
            endcase
        end
    end

    assign PRDATA  = prdata_r;
    assign PREADY  = PSEL && PENABLE;
    assign PSLVERR = PSEL && PENABLE && !hit;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    property p_cycle_len;
        (ph_r == 3'h0) |-> ##7 cyc_end ##1 (ph_r == 3'h0);
    endproperty
    a_cycle_len: assert property (p_cycle_len) else $error("Cycle not eight clocks");

    property p_alp_once;
        bus_r.address_high_latch_pulse |=> !bus_r.address_high_latch_pulse [*7];
    endproperty
    a_alp_once: assert property (p_alp_once) else $error("Latch pulse repeats");

    property p_low_after;
        (ph_r == 3'h4 && !halted) |-> (bus_r.addr == addr[7:0]);
    endproperty
    a_low_after: assert property (p_low_after) else $error("Low byte not on bus");

    property p_strobes;
        !(!bus_r.rd_n && !bus_r.wr_n);
    endproperty
    a_strobes: assert property (p_strobes) else $error("Read and write together");

    property p_inherent;
        (in_exec && inherent) |=> (bus_r.rd_n && bus_r.wr_n);
    endproperty
    a_inherent: assert property (p_inherent) else $error("Memory active on inherent");

    property p_dma_inc;
        (st_r == ST_DMA && cyc_end) |=> (ptr_r[0] == $past(ptr_r[0]) + 16'h0001);
    endproperty
    a_dma_inc: assert property (p_dma_inc) else $error("DMA pointer not advanced");

    property p_out_inc;
        (in_exec && output_instr && cyc_end) |=> (x_r == $past(x_r))
            && (cur_x == $past(cur_x) + 16'h0001);
    endproperty
    a_out_inc: assert property (p_out_inc) else $error("Stack pointer not advanced");

    property p_intr;
        (st_r == ST_INTR && cyc_end) |=> (p_r == INT_P && x_r == INT_X && !ie_r);
    endproperty
    a_intr: assert property (p_intr) else $error("Interrupt entry wrong");

    property p_dma_next;
        (cyc_end && st_r != ST_FETCH && !(in_exec && ir_i == OP_LBR)
            && run_r && DMA_IN_REQ) |=> (st_r == ST_DMA) [*8];
    endproperty
    a_dma_next: assert property (p_dma_next) else $error("DMA cycle not taken");

    property p_io_sel;
        (bus_r.io_sel != 3'h0) |-> $past(in_exec && ir_i == OP_IO);
    endproperty
    a_io_sel: assert property (p_io_sel) else $error("Select outside I/O");

    c_dma_pair: cover property ((st_r == ST_DMA) [*8] ##1 (st_r == ST_DMA));
    c_long_br: cover property (st_r == ST_EXEC2 && cyc_end);
    c_intr: cover property (st_r == ST_INTR && cyc_end);
    c_output: cover property (in_exec && output_instr && cyc_end);

endmodule : cbc_cpu_bus_ctrl

// ===== cbc_mem_model.sv
// Partner model: external memory, high-byte address latch and one I/O port.
// Assumes the bus struct of cbc_pkg and the device's own clock.
module cbc_mem_model (
    input  wire logic              clk,
    input  wire cbc_pkg::cbc_bus_s bus,
    input  wire logic [7:0]        io_byte,
    output logic      [7:0]        data_in
);
    timeunit 1ns;
    timeprecision 1ns;
    import cbc_pkg::*;
    logic [7:0]  mem [0:65535];
    logic [7:0]  hi_r;
    logic [7:0]  last_r;
    logic [7:0]  out_byte;
    logic [2:0]  out_sel;
    logic [15:0] out_addr;
    int          gap;
    int          bad_gaps;
    int          dma_cnt;
    wire  [15:0] addr = {hi_r, bus.addr};
    initial begin
        for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
        hi_r = 8'h00;
        last_r = 8'h00;
        gap = 0;
        bad_gaps = 0;
        dma_cnt = 0;
    end
    // Undriven bus toggles so that stale data is never mistaken for a read
    always_comb begin
        if (!bus.rd_n) data_in = mem[addr];
        else if (!bus.wr_n && !bus.doe) data_in = io_byte;
        else data_in = ~last_r;
    end
    always @(posedge clk) begin
        last_r <= data_in;
        // Spacing is judged only after a first latch pulse has been seen
        gap <= bus.address_high_latch_pulse ? 1 : ((gap > 0) ? gap + 1 : 0);
        if (bus.address_high_latch_pulse) begin
            hi_r <= bus.addr;
            if (gap > 0 && gap % 8 != 0) bad_gaps <= bad_gaps + 1;
        end
        if (bus.data_latch_pulse && !bus.wr_n) mem[addr] <= bus.doe ? bus.dout : data_in;
        if (bus.data_latch_pulse && bus.io_sel != 3'h0 && !bus.rd_n) begin
            out_byte <= data_in;
            out_addr <= addr;
            out_sel <= bus.io_sel;
        end
        if (bus.data_latch_pulse && bus.state_code == SC_DMA) dma_cnt <= dma_cnt + 1;
    end
endmodule : cbc_mem_model

// ===== test_cpu_bus_cycle_control.sv
// Testbench: a short program, DMA and an interrupt, steered over APB.
// Assumes the model's memory is preloaded through the hierarchy after reset.
module test_cpu_bus_cycle_control;
    timeunit 1ns;
    timeprecision 1ns;
    import cbc_pkg::*;
    logic        CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic        DMA_IN_REQ, INT_REQ, Q_OUT, err;
    logic [7:0]  PADDR, DATA_IN, io_byte;
    logic [31:0] PWDATA, PRDATA, rd_q;
    logic [3:0]  FLAG_IN;
    cbc_bus_s    BUS;
    int          checks, miscompares, n;
    cbc_cpu_bus_ctrl cbc_cpu_bus_ctrl_i (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .DATA_IN(DATA_IN), .FLAG_IN(FLAG_IN), .DMA_IN_REQ(DMA_IN_REQ),
        .INT_REQ(INT_REQ), .Q_OUT(Q_OUT), .BUS(BUS));
    cbc_mem_model cbc_mem_model_i (.clk(CLK), .bus(BUS), .io_byte(io_byte), .data_in(DATA_IN));
    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end
    task automatic stop_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        k = 0;
        do begin
            @(posedge CLK);
            k++;
        end while (PREADY !== 1'b1 && k < 16);
        if (k >= 16) begin
            $display("[ERR] pready expected 1 seen %h", PREADY);
            miscompares++;
            stop_test();
        end
        rd_q = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd_q);
    endtask : rd
    task automatic ptr(input logic [3:0] i, input logic [15:0] v, input logic w);
        apb(1'b1, A_PIDX, {28'h0, i});
        if (w) apb(1'b1, A_PDATA, {16'h0, v});
        else rd(A_PDATA, {16'h0, v}, $sformatf("pointer %0d", i));
    endtask : ptr
    initial begin
        RST = 1'b1;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 8'h00;
        PWDATA = 32'h0;
        FLAG_IN = 4'h1;
        DMA_IN_REQ = 1'b0;
        INT_REQ = 1'b0;
        io_byte = 8'h77;
        checks = 0;
        miscompares = 0;
        repeat (3) @(posedge CLK);
        RST <= 1'b0;
        rd(A_STAT, 32'h10, "status after reset");
        chk("strobes idle", 32'h3, {30'h0, BUS.rd_n, BUS.wr_n});
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        $display("test reset done");
        // Inc, dec twice, load, store, set Q, output, input, short branch
        {cbc_mem_model_i.mem[16'h1000], cbc_mem_model_i.mem[16'h1001]} = 16'h1525;
        {cbc_mem_model_i.mem[16'h1002], cbc_mem_model_i.mem[16'h1003]} = 16'h2545;
        {cbc_mem_model_i.mem[16'h1004], cbc_mem_model_i.mem[16'h1005]} = 16'h557b;
        {cbc_mem_model_i.mem[16'h1006], cbc_mem_model_i.mem[16'h1007]} = 16'h6169;
        {cbc_mem_model_i.mem[16'h1008], cbc_mem_model_i.mem[16'h1009]} = 16'h3020;
        cbc_mem_model_i.mem[16'h100a] = 8'h1f;
        {cbc_mem_model_i.mem[16'h1020], cbc_mem_model_i.mem[16'h1021]} = 16'hc011;
        // Branch target: inc, new stack select, output through it, untaken branch, inc
        {cbc_mem_model_i.mem[16'h1100], cbc_mem_model_i.mem[16'h1101]} = 16'h1ee5;
        {cbc_mem_model_i.mem[16'h1102], cbc_mem_model_i.mem[16'h1103]} = 16'h6232;
        {cbc_mem_model_i.mem[16'h1104], cbc_mem_model_i.mem[16'h1105]} = 16'h5515;
        // Service entry clears Q, so the vector is proven to be used
        cbc_mem_model_i.mem[16'h1200] = 8'h7a;
        cbc_mem_model_i.mem[16'h3fff] = 8'ha5;
        cbc_mem_model_i.mem[16'h2000] = 8'h5c;
        ptr(4'h2, 16'h1000, 1'b1);
        ptr(4'h3, 16'h2000, 1'b1);
        ptr(4'h0, 16'h3000, 1'b1);
        ptr(4'h5, 16'h4000, 1'b1);
        ptr(4'h1, 16'h1200, 1'b1);
        apb(1'b1, A_SEL, 32'h32);
        apb(1'b1, A_CTRL, 32'h1);
        // Program needs about 32 machine cycles of fixed length
        repeat (40 * CYC_CLKS) @(posedge CLK);
        chk("q set", 32'h1, {31'h0, Q_OUT});
        DMA_IN_REQ <= 1'b1;
        repeat (3 * CYC_CLKS) @(posedge CLK);
        DMA_IN_REQ <= 1'b0;
        repeat (2 * CYC_CLKS) @(posedge CLK);
        apb(1'b1, A_CTRL, 32'h3);
        INT_REQ <= 1'b1;
        repeat (3 * CYC_CLKS) @(posedge CLK);
        INT_REQ <= 1'b0;
        apb(1'b1, A_SEL, 32'hff);
        apb(1'b1, A_CTRL, 32'h0);
        n = 0;
        do begin
            apb(1'b0, A_STAT, 32'h0);
            n++;
        end while (rd_q[4] !== 1'b1 && n < 20);
        if (n >= 20) begin
            $display("[ERR] halt status expected 1 seen %h", rd_q[4]);
            miscompares++;
            stop_test();
        end
        $display("test run done");
        chk("status", 32'h0077_2110, rd_q & 32'h00ff_ff1c);
        chk("q cleared", 32'h0, {31'h0, Q_OUT});
        ptr(4'h5, 16'h4002, 1'b0);
        ptr(4'h3, 16'h2001, 1'b0);
        ptr(4'he, 16'h0001, 1'b0);
        ptr(4'hf, 16'h0000, 1'b0);
        ptr(4'h0, 16'h3000 + 16'(cbc_mem_model_i.dma_cnt), 1'b0);
        chk("dma cycles", 32'h1, {31'h0, cbc_mem_model_i.dma_cnt >= 2});
        chk("dma bytes", 32'h7777,
            {16'h0, cbc_mem_model_i.mem[16'h3000], cbc_mem_model_i.mem[16'h3001]});
        chk("stored byte", 32'ha5, {24'h0, cbc_mem_model_i.mem[16'h4000]});
        chk("input byte", 32'h77, {24'h0, cbc_mem_model_i.mem[16'h2001]});
        chk("output byte", 32'ha5, {24'h0, cbc_mem_model_i.out_byte});
        chk("output addr", 32'h4000, {16'h0, cbc_mem_model_i.out_addr});
        chk("io select", 32'h2, {29'h0, cbc_mem_model_i.out_sel});
        chk("program untouched", 32'h1e, {24'h0, cbc_mem_model_i.mem[16'h1100]});
        chk("cycle spacing", 32'h0, cbc_mem_model_i.bad_gaps);
        $display("test checks done");
        stop_test();
    end
endmodule : test_cpu_bus_cycle_control
